/* verilog/eip_ctrl.sv */
// Purpose: extended interrupt enables, four-level priority and preemption control
// Assumes: classic requests arrive already gated by their own enables
// Notes: only the low byte lane carries data; upper bits read zero
//   one in-service bit per level, so nesting unwinds level by level
// How it works
// - pwm request forwarded only when enable bit 7
// - comparator request gated by enable bit 6
// - pulse gen/detect request gated by bit 5
// - i2c gated by bit 4, adc by bit 3
// - bit 2 enables pin2 irq and stop wake
// - port1 change request gated by bit 1
// - timer3 request gated by enable bit 0
// - level is {high bit, low bit}, 3 highest
// - timer2 level from classic bit 5
// - serial level from classic bit 4
// - timer1 bit 3, pin1 bit 2
// - timer0 bit 1, pin0 bit 0
// - pwm level from extended bit 7
// - comparator bit 6, pulse bit 5
// - i2c bit 4, adc bit 3
// - pin2 bit 2, port1 bit 1, timer3 bit 0
// - extended enable and priorities reset to zero
// - only higher level preempts; preempted handler resumes
// - equal or lower level waits for completion
module eip_ctrl
(
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// axi4-lite write address and data
	input wire logic [eip_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [eip_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// peripheral requests
	input wire logic [eip_pkg::NCLS-1:0] cls_req,
	input wire logic [eip_pkg::NEXT-1:0] ext_req,
	input wire logic global_irq_en,
	// cpu core side
	output eip_pkg::eip_grant_s cpu_grant,
	input wire logic cpu_ack,
	input wire logic cpu_return,
	output logic stop_wake
);
	// software registers
	logic [7:0] ext_en_ff; // extended enable
	logic [5:0] cls_lo_ff; // classic priority low bits
	logic [5:0] cls_hi_ff; // classic priority high bits
	logic [7:0] ext_lo_ff; // extended priority low bits
	logic [7:0] ext_hi_ff; // extended priority high bits
	// service state: one bit per level in service
	logic [3:0] in_svc_ff;
	// bus state
	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic aw_got_ff, w_got_ff;
	logic [eip_pkg::ADDR_W-1:0] awaddr_ff;
	logic [7:0] wbyte_ff;
	logic wlane_ff; // low byte lane was strobed
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	// cpu side outputs
	eip_pkg::eip_grant_s grant_ff;
	logic stop_wake_ff;
	// request vector and levels in vector order
	logic [eip_pkg::NSRC-1:0] req_vec;
	logic [1:0] lvl [eip_pkg::NSRC];
	// arbiter results
	logic best_ok;
	logic [3:0] best_id;
	logic [1:0] best_lvl;
	logic svc_any;
	logic [1:0] svc_top;
	logic nxt_grant;
	logic do_write;
	eip_pkg::eip_sel_e wsel;
	eip_pkg::eip_sel_e rsel;

	// map a byte address to a register
	function automatic eip_pkg::eip_sel_e dec_addr(input logic [eip_pkg::ADDR_W-1:0] a);
		logic [7:0] idx;
		idx = a[eip_pkg::IDX_LSB +: 8];
		// misaligned addresses select nothing
		if (a[eip_pkg::IDX_LSB-1:0] != 2'h0)
			return eip_pkg::SEL_NONE;
		// bits above the index would otherwise alias every register
		if (a[eip_pkg::ADDR_W-1:eip_pkg::IDX_LSB+8] != '0)
			return eip_pkg::SEL_NONE;
		case (idx)
			eip_pkg::EXT_EN_IDX: return eip_pkg::SEL_EXT_EN;
			eip_pkg::CLS_LO_IDX: return eip_pkg::SEL_CLS_LO;
			eip_pkg::CLS_HI_IDX: return eip_pkg::SEL_CLS_HI;
			eip_pkg::EXT_LO_IDX: return eip_pkg::SEL_EXT_LO;
			eip_pkg::EXT_HI_IDX: return eip_pkg::SEL_EXT_HI;
			eip_pkg::STATUS_IDX: return eip_pkg::SEL_STATUS;
			default: return eip_pkg::SEL_NONE;
		endcase
	endfunction

	// highest level currently in service
	function automatic logic [1:0] top_level(input logic [3:0] s);
		logic [1:0] t;
		t = 2'h0;
		// ascending scan: the last set bit seen is the highest
		for (int i = 0; i < 4; i++)
			if (s[i])
				t = 2'(i);
		return t;
	endfunction

	// writes decode the held address, reads the live one at their handshake
	assign wsel = dec_addr(awaddr_ff);
	assign rsel = dec_addr(araddr);
	// a write lands once both halves are held and no response is waiting
	assign do_write = aw_got_ff & w_got_ff & ~bvalid_ff;

	// classic sources: already gated outside, level from the classic pair
	genvar gi;
	generate
		for (gi = 0; gi < eip_pkg::NCLS; gi++)
		begin : g_cls
			assign req_vec[gi] = cls_req[gi];
			assign lvl[gi] = {cls_hi_ff[gi], cls_lo_ff[gi]};
		end
		// extended sources sit after timer2 in vector order
		for (gi = 0; gi < eip_pkg::NEXT; gi++)
		begin : g_ext
			// each request is passed only while its enable bit is one
			assign req_vec[eip_pkg::NCLS+gi] = ext_req[gi] & ext_en_ff[gi];
			assign lvl[eip_pkg::NCLS+gi] = {ext_hi_ff[gi], ext_lo_ff[gi]};
		end
	endgenerate

	// pick the highest level; descending scan with >= leaves the lowest vector on ties
	always_comb
	begin
		// no winner until a live request is seen
		best_ok = 1'b0;
		best_id = 4'h0;
		best_lvl = 2'h0;
		for (int i = eip_pkg::NSRC - 1; i >= 0; i--)
		begin
			if (req_vec[i] && (!best_ok || lvl[i] >= best_lvl))
			begin
				best_ok = 1'b1;
				best_id = 4'(i);
				best_lvl = lvl[i];
			end
		end
	end

	// a winner is offered only if it outranks every handler in service
	always_comb
	begin
		svc_any = |in_svc_ff;
		svc_top = top_level(in_svc_ff);
		nxt_grant = global_irq_en & best_ok & (~svc_any | (best_lvl > svc_top));
	end

	// offer to the cpu; dropped for one cycle after an ack so one request is not taken twice
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			grant_ff <= '0; // nothing offered out of reset
		else if (ce)
		begin
			grant_ff.valid <= nxt_grant & ~(cpu_ack & grant_ff.valid);
			// src and level track the winner even while nothing is offered
			grant_ff.src <= best_id;
			grant_ff.level <= best_lvl;
		end
	end

	// in-service levels: ack pushes the taken level, return pops the highest
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			in_svc_ff <= 4'h0;
		else if (ce)
		begin
			// an ack and a return in one cycle: the ack wins, the return is lost
			if (cpu_ack && grant_ff.valid)
				in_svc_ff[grant_ff.level] <= 1'b1;
			// only the innermost handler ends, so the one it preempted resumes
			else if (cpu_return && svc_any)
				in_svc_ff[svc_top] <= 1'b0;
		end
	end

	// stop-mode wake from the third pin ignores the global enable
	// limitation: the pin request is taken as a level; its edge flag lives outside
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			stop_wake_ff <= 1'b0;
		else if (ce)
			stop_wake_ff <= ext_en_ff[eip_pkg::PIN2_BIT] & ext_req[eip_pkg::PIN2_BIT];
	end

	// write address channel: hold one address until the response is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_ff <= 1'b1;
			aw_got_ff <= 1'b0;
			awaddr_ff <= '0;
		end
		else if (ce)
		begin
			// take the address and close the channel until the response
			if (awvalid && awready_ff)
			begin
				awready_ff <= 1'b0;
				aw_got_ff <= 1'b1;
				awaddr_ff <= awaddr;
			end
			// address consumed by the write
			else if (do_write)
				aw_got_ff <= 1'b0;
			// reopen once the response is taken
			else if (bvalid_ff && bready)
				awready_ff <= 1'b1;
		end
	end

	// write data channel: may arrive before or after the address
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wready_ff <= 1'b1;
			w_got_ff <= 1'b0;
			wbyte_ff <= 8'h00;
			wlane_ff <= 1'b0;
		end
		else if (ce)
		begin
			// take the data and close the channel until the response
			if (wvalid && wready_ff)
			begin
				wready_ff <= 1'b0;
				w_got_ff <= 1'b1;
				wbyte_ff <= wdata[7:0];
				wlane_ff <= wstrb[0];
			end
			// data consumed by the write
			else if (do_write)
				w_got_ff <= 1'b0;
			// reopen once the response is taken
			else if (bvalid_ff && bready)
				wready_ff <= 1'b1;
		end
	end

	// write response one edge after both halves are held
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_ff <= 1'b0;
			bresp_ff <= eip_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			// unmapped targets answer with an error and nothing is written
			if (do_write)
			begin
				bvalid_ff <= 1'b1;
				bresp_ff <= (wsel == eip_pkg::SEL_NONE) ? eip_pkg::RESP_SLVERR
					: eip_pkg::RESP_OKAY;
			end
			// response taken by the master
			else if (bvalid_ff && bready)
				bvalid_ff <= 1'b0;
		end
	end

	// register file; only the low byte lane carries data, status is read-only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ext_en_ff <= eip_pkg::EXT_RST;
			ext_lo_ff <= eip_pkg::EXT_RST;
			ext_hi_ff <= eip_pkg::EXT_RST;
			cls_lo_ff <= eip_pkg::CLS_RST;
			cls_hi_ff <= eip_pkg::CLS_RST;
		end
		// a cleared low strobe leaves every register as it was
		else if (ce && do_write && wlane_ff)
		begin
			case (wsel)
				eip_pkg::SEL_EXT_EN: ext_en_ff <= wbyte_ff;
				// the classic pair keeps only its six implemented bits
				eip_pkg::SEL_CLS_LO: cls_lo_ff <= wbyte_ff[5:0];
				eip_pkg::SEL_CLS_HI: cls_hi_ff <= wbyte_ff[5:0];
				eip_pkg::SEL_EXT_LO: ext_lo_ff <= wbyte_ff;
				eip_pkg::SEL_EXT_HI: ext_hi_ff <= wbyte_ff;
				default: ;
			endcase
		end
	end

	// read channel: data captured at the address handshake
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= eip_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (arvalid && arready_ff)
			begin
				arready_ff <= 1'b0;
				rvalid_ff <= 1'b1;
				rresp_ff <= eip_pkg::RESP_OKAY;
				// unused upper bits read as zero
				rdata_ff <= 32'h0000_0000;
				case (rsel)
					eip_pkg::SEL_EXT_EN: rdata_ff[7:0] <= ext_en_ff;
					eip_pkg::SEL_CLS_LO: rdata_ff[5:0] <= cls_lo_ff;
					eip_pkg::SEL_CLS_HI: rdata_ff[5:0] <= cls_hi_ff;
					eip_pkg::SEL_EXT_LO: rdata_ff[7:0] <= ext_lo_ff;
					eip_pkg::SEL_EXT_HI: rdata_ff[7:0] <= ext_hi_ff;
					eip_pkg::SEL_STATUS:
					begin
						rdata_ff[eip_pkg::ST_SVC_LSB +: 4] <= in_svc_ff;
						rdata_ff[eip_pkg::ST_VALID_BIT] <= grant_ff.valid;
						rdata_ff[eip_pkg::ST_LVL_LSB +: 2] <= grant_ff.level;
					end
					// unmapped reads return zero with an error
					default: rresp_ff <= eip_pkg::RESP_SLVERR;
				endcase
			end
			// reopen the address channel once the data is taken
			else if (rvalid_ff && rready)
			begin
				rvalid_ff <= 1'b0;
				arready_ff <= 1'b1;
			end
		end
	end

	// outputs straight from flip-flops
	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = arready_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	assign cpu_grant = grant_ff;
	assign stop_wake = stop_wake_ff;
endmodule

/* verilog/eip_pkg.sv */
// Purpose: constants and types shared by the extended interrupt enable/priority block
// Assumes: 32-bit AXI4-Lite register port, byte address = 4 * register index
// Notes: source numbering follows vector order, lowest vector first
package eip_pkg;
	// register indices as printed; byte address is four times the index
	localparam logic [7:0] EXT_EN_IDX = 8'hA9;
	localparam logic [7:0] CLS_LO_IDX = 8'hB8;
	localparam logic [7:0] CLS_HI_IDX = 8'hB9;
	localparam logic [7:0] EXT_LO_IDX = 8'hBA;
	localparam logic [7:0] EXT_HI_IDX = 8'hBB;
	localparam logic [7:0] STATUS_IDX = 8'hC0;
	// address width and word alignment
	localparam int ADDR_W = 12;
	localparam int IDX_LSB = 2;
	// reset values
	localparam logic [7:0] EXT_RST = 8'h00;
	localparam logic [5:0] CLS_RST = 6'h00;
	// widths of the source groups
	localparam int NCLS = 6;
	localparam int NEXT = 8;
	localparam int NSRC = 14;
	// extended enable field positions
	localparam int TIMER3_BIT = 0;
	localparam int PORT1_BIT = 1;
	localparam int PIN2_BIT = 2;
	localparam int ADC_BIT = 3;
	localparam int I2C_BIT = 4;
	localparam int PULSE_BIT = 5;
	localparam int CMP_BIT = 6;
	localparam int PWM_BIT = 7;
	// status register field positions
	localparam int ST_SVC_LSB = 0;
	localparam int ST_VALID_BIT = 4;
	localparam int ST_LVL_LSB = 5;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// register selector
	typedef enum logic [2:0]
	{
		SEL_NONE = 3'h0,
		SEL_EXT_EN = 3'h1,
		SEL_CLS_LO = 3'h2,
		SEL_CLS_HI = 3'h3,
		SEL_EXT_LO = 3'h4,
		SEL_EXT_HI = 3'h5,
		SEL_STATUS = 3'h6
	} eip_sel_e;
	// request offered to the cpu core
	typedef struct packed
	{
		logic valid;
		logic [3:0] src;
		logic [1:0] level;
	} eip_grant_s;
endpackage

/* verification/eip_sva.sv */
// Purpose: port-level checks for eip_ctrl
// Assumes: ce held high, so every edge is a working edge
// Notes: in-service levels are mirrored here from ack and return
module eip_sva
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	// requests and core side
	input wire logic [5:0] cls_req,
	input wire logic [7:0] ext_req,
	input wire eip_pkg::eip_grant_s cpu_grant,
	input wire logic cpu_ack,
	input wire logic cpu_return,
	input wire logic stop_wake
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// requests as the design saw them one edge ago
	logic [5:0] cls_seen_ff;
	logic [7:0] ext_seen_ff;
	// mirror of levels in service
	logic [3:0] svc_ff;
	always_ff @(posedge aclk)
	begin
		cls_seen_ff <= cls_req;
		ext_seen_ff <= ext_req;
	end
	// ack sets its level; return drops only the highest, as nesting unwinds
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			svc_ff <= 4'h0;
		else if (cpu_ack && cpu_grant.valid)
			svc_ff <= svc_ff | (4'h1 << cpu_grant.level);
		else if (cpu_return)
			svc_ff <= svc_ff & (svc_ff[3] ? 4'h7 : svc_ff[2] ? 4'h3 : svc_ff[1] ? 4'h1 : 4'h0);
	end
	sequence s_wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_rd_taken;
		arvalid && arready;
	endsequence
	chk_wake_cause: assert property (stop_wake |-> $past(ext_req[2]))
		else $error("wake without third pin request");
	chk_grant_src: assert property (cpu_grant.valid |->
		(cpu_grant.src < 4'h6 ? cls_seen_ff[cpu_grant.src]
			: ext_seen_ff[cpu_grant.src - 4'h6]))
		else $error("grant for an idle source");
	chk_ack_drop: assert property (cpu_ack && cpu_grant.valid |=> !cpu_grant.valid)
		else $error("grant kept after ack");
	chk_svc_level: assert property (cpu_grant.valid |->
		($past(svc_ff) >> cpu_grant.level) == 4'h0)
		else $error("grant not above level in service");
	chk_b_answer: assert property (s_wr_taken |-> ##2 bvalid)
		else $error("write response late");
	chk_b_hold: assert property (bvalid && !bready |=> bvalid)
		else $error("write response dropped");
	chk_r_answer: assert property (s_rd_taken |=> rvalid)
		else $error("read data late");
	chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data not held");
	chk_rdata_top: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("upper read bits set");
endmodule

bind eip_ctrl eip_sva u_sva (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
	.bready, .arvalid, .arready, .rdata, .rvalid, .rready, .cls_req, .ext_req, .cpu_grant,
	.cpu_ack, .cpu_return, .stop_wake);

/* verification/eip_cpu_model.sv */
// Purpose: cpu core stand-in that takes grants and ends handlers
// Assumes: the bench holds take until it sees cpu_ack
// Notes: ack lasts one cycle so one grant is never taken twice
module eip_cpu_model
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bench control
	input wire logic take,
	input wire logic fin,
	// design side
	input wire eip_pkg::eip_grant_s cpu_grant,
	output logic cpu_ack,
	output logic cpu_return
);
	timeunit 1ns;
	timeprecision 1ps;
	// ack an offered grant; a return follows the bench's fin pulse
	always_ff @(posedge aclk)
	begin
		cpu_ack <= aresetn && take && cpu_grant.valid && !cpu_ack;
		cpu_return <= aresetn && fin;
	end
endmodule

/* verification/testbench.sv */
// Purpose: self-checking bench for eip_ctrl
// Assumes: ce held high; wstrb lowered only for the strobe test
// Notes: grants are sampled three edges after their inputs change
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = '0;
	logic aresetn = '0;
	logic ce = '1;
	logic [11:0] awaddr = '0;
	logic [11:0] araddr = '0;
	logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
	logic awready, wready, bvalid, arready, rvalid, cpu_ack, cpu_return, stop_wake;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp, rs, bs, lv;
	logic [31:0] rdata, rv;
	logic [5:0] cls_req = '0;
	logic [7:0] ext_req = '0;
	logic global_irq_en = '0, take = '0, fin = '0;
	logic [13:0] hi, lo;
	eip_pkg::eip_grant_s cpu_grant;
	int errors = 0;
	int cmp_count = 0;
	logic [7:0] idx [5] = '{eip_pkg::EXT_EN_IDX, eip_pkg::CLS_LO_IDX, eip_pkg::CLS_HI_IDX,
		eip_pkg::EXT_LO_IDX, eip_pkg::EXT_HI_IDX};
	always #2.5 aclk = ~aclk;
	eip_ctrl u_dut (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .cls_req, .ext_req, .global_irq_en, .cpu_grant, .cpu_ack, .cpu_return, .stop_wake);
	eip_cpu_model u_cpu (.aclk, .aresetn, .take, .fin, .cpu_grant, .cpu_ack, .cpu_return);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// src and level only mean something while valid
	task automatic chk_grant(input logic v, input logic [3:0] s, input logic [1:0] l);
		repeat (3) @(posedge aclk);
		chk(v ? {25'h0, cpu_grant} : {31'h0, cpu_grant.valid}, {25'h0, v, s, l});
	endtask
	// each channel is released at its own handshake; late bready lets the response wait
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		awaddr <= {2'h0, i, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= '1;
		wvalid <= '1;
		while (!(aw_done && w_done))
		begin
			@(posedge aclk);
			if (!aw_done && awready)
			begin
				aw_done = 1'b1;
				awvalid <= '0;
			end
			if (!w_done && wready)
			begin
				w_done = 1'b1;
				wvalid <= '0;
			end
		end
		repeat (2) @(posedge aclk);
		bready <= '1;
		do @(posedge aclk); while (!bvalid);
		bs = bresp;
		bready <= '0;
	endtask
	task automatic rd(input logic [7:0] i);
		@(posedge aclk);
		araddr <= {2'h0, i, 2'h0};
		arvalid <= '1;
		do @(posedge aclk); while (!arready);
		arvalid <= '0;
		@(posedge aclk);
		rready <= '1;
		do @(posedge aclk); while (!rvalid);
		rv = rdata;
		rs = rresp;
		rready <= '0;
	endtask
	task automatic clr;
		for (int i = 1; i < 5; i++)
			wr(idx[i], 8'h00);
	endtask
	task automatic serve;
		take <= '1;
		do @(posedge aclk); while (!cpu_ack);
		take <= '0;
	endtask
	task automatic ret;
		fin <= '1;
		@(posedge aclk);
		fin <= '0;
	endtask
	task automatic test_done;
		$display("errors %0d, comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// watchdog, far beyond the several hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge aclk);
		errors++;
		test_done;
	end
	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= '1;
		// reset values, then readback; classic bits 7:6 stay zero
		for (int i = 0; i < 5; i++)
		begin
			rd(idx[i]);
			chk(rv, 32'h0);
			wr(idx[i], 8'hC5 + 8'(i));
			rd(idx[i]);
			chk(rv, {24'h0, 8'hC5 + 8'(i)} & ((i == 1 || i == 2) ? 32'h3F : 32'hFF));
		end
		// unmapped index
		rd(8'hC4);
		chk(rv, 32'h0);
		chk({30'h0, rs}, {30'h0, eip_pkg::RESP_SLVERR});
		wr(8'hC4, 8'hFF);
		chk({30'h0, bs}, {30'h0, eip_pkg::RESP_SLVERR});
		// a cleared low strobe leaves the register untouched
		wstrb <= 4'hE;
		wr(eip_pkg::EXT_LO_IDX, 8'h00);
		wstrb <= 4'hF;
		chk({30'h0, bs}, {30'h0, eip_pkg::RESP_OKAY});
		rd(eip_pkg::EXT_LO_IDX);
		chk(rv, 32'hC8);
		clr;
		// each extended request passes only under its own enable
		global_irq_en <= '1;
		for (int b = 0; b < 8; b++)
		begin
			ext_req <= 8'h01 << b;
			wr(eip_pkg::EXT_EN_IDX, ~(8'h01 << b));
			chk_grant('0, 4'h0, 2'h0);
			wr(eip_pkg::EXT_EN_IDX, 8'h01 << b);
			chk_grant('1, 4'(6 + b), 2'h0);
		end
		// third pin wakes the core with the global enable off
		ext_req <= 8'h04;
		wr(eip_pkg::EXT_EN_IDX, 8'h04);
		global_irq_en <= '0;
		chk_grant('0, 4'h0, 2'h0);
		chk({31'h0, stop_wake}, 32'h1);
		// with its enable off the pin no longer wakes the core
		wr(eip_pkg::EXT_EN_IDX, 8'hFB);
		chk_grant('0, 4'h0, 2'h0);
		chk({31'h0, stop_wake}, 32'h0);
		// one source at a time lifted above all others
		global_irq_en <= '1;
		cls_req <= 6'h3F;
		ext_req <= 8'hFF;
		wr(eip_pkg::EXT_EN_IDX, 8'hFF);
		for (int s = 0; s < 14; s++)
		begin
			lv = 2'(s % 3 + 1);
			hi = {14{lv[1]}} & (14'h1 << s);
			lo = {14{lv[0]}} & (14'h1 << s);
			wr(eip_pkg::CLS_LO_IDX, {2'h0, lo[5:0]});
			wr(eip_pkg::CLS_HI_IDX, {2'h0, hi[5:0]});
			wr(eip_pkg::EXT_LO_IDX, lo[13:6]);
			wr(eip_pkg::EXT_HI_IDX, hi[13:6]);
			chk_grant('1, 4'(s), lv);
		end
		clr;
		chk_grant('1, 4'h0, 2'h0);
		// level 1 in service holds back another level 1, level 2 cuts in
		cls_req <= 6'h00;
		ext_req <= 8'h80;
		wr(eip_pkg::EXT_LO_IDX, 8'h81);
		chk_grant('1, 4'hD, 2'h1);
		serve;
		ext_req <= 8'h81;
		chk_grant('0, 4'h0, 2'h0);
		ext_req <= 8'h89;
		wr(eip_pkg::EXT_HI_IDX, 8'h08);
		chk_grant('1, 4'h9, 2'h2);
		// status: level 1 in service, grant valid at level 2
		rd(eip_pkg::STATUS_IDX);
		chk(rv, 32'h52);
		serve;
		ext_req <= 8'h81;
		ret;
		chk_grant('0, 4'h0, 2'h0);
		ret;
		chk_grant('1, 4'h6, 2'h1);
		test_done;
	end
endmodule
